// ==== rtl/qdw_dev.sv ====
// Converter end: serial write port and channel registers
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// How it works
// - High data byte is 8-bit conversion value
// - Control bit zero: high byte bits 7,6 power-down
// - Master always sends low byte for update
// - Update on falling edge ending low-byte acknowledge
// - Reset clears temporary and converter registers to zero
// - Control byte held in 8-bit register
// - High byte latched in 8-bit staging register
// - Four 10-bit temporary registers, code plus data
// - Four 10-bit converter registers drive outputs
// - Write starts with address, write bit zero
// - Control byte picks action and channel
// - Control bit zero selects power-down handling
// - Flag clear: byte pairs repeat until stop
// - Flag set: exactly two power-down bytes
// - Address 10011 plus two pins, acknowledged
// - Power-down high byte: code, six zeros
// - Each high byte followed by low byte
// - Master sends a start and a stop for each write, no repeated start
// - Load modes 00, 01, 10 select updates
// - Mode 11 broadcast: stored or new data
// - Select 00..11 address channels A..D
module qdw_dev (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  // Link
  qdw_link_if.dev         link,
  // Address straps
  input  wire logic       addr_pin_hi_in,
  input  wire logic       addr_pin_lo_in,
  // Converter register contents and update strobe
  output logic [9:0]      conv_channel_a_out,
  output logic [9:0]      conv_channel_b_out,
  output logic [9:0]      conv_channel_c_out,
  output logic [9:0]      conv_channel_d_out,
  output logic            update_out
);
  logic [3:0]             sync1_q;
  logic [3:0]             sync2_q;
  logic                   scl_d3_q;
  logic                   sda_d3_q;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_seen;
  logic                   stop_seen;
  logic [3:0]             cnt_q;
  logic [6:0]             shift_q;
  logic [7:0]             byte_val;
  logic                   byte_done;
  logic                   ack_end;
  logic                   ack_ok_q;
  logic                   ack_ok_d;
  logic                   sda_oe_q;
  qdw_pkg::qdw_phase_t    phase_q;
  qdw_pkg::qdw_phase_t    phase_d;
  logic [7:0]             control_byte_store_q;
  logic [7:0]             high_byte_staging_q;
  logic [9:0]             temp_q [qdw_pkg::CHANNELS];
  logic [9:0]             conv_q [qdw_pkg::CHANNELS];
  logic [9:0]             new_val;
  logic [1:0]             load_mode;
  logic [1:0]             sel;
  logic                   powerdown_select_flag;
  logic                   do_update;
  logic                   update_q;

  // Pins pass two flops; scl/sda get a third for edge finding
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q  <= 4'hf;
      sync2_q  <= 4'hf;
      scl_d3_q <= 1'b1;
      sda_d3_q <= 1'b1;
    end else begin
      sync1_q  <= {link.scl, link.sda, addr_pin_hi_in, addr_pin_lo_in};
      sync2_q  <= sync1_q;
      scl_d3_q <= sync2_q[3];
      sda_d3_q <= sync2_q[2];
    end
  end

  // Bus events from synchronised levels
  assign scl_rise   = sync2_q[3] & ~scl_d3_q;
  assign scl_fall   = ~sync2_q[3] & scl_d3_q;
  assign start_seen = sync2_q[3] & scl_d3_q & ~sync2_q[2] & sda_d3_q;
  assign stop_seen  = sync2_q[3] & scl_d3_q & sync2_q[2] & ~sda_d3_q;
  assign byte_val   = {shift_q, sync2_q[2]};
  assign byte_done  = scl_rise & (cnt_q == 4'h7) &
                      (phase_q != qdw_pkg::PH_IDLE);
  assign ack_end    = scl_fall & (cnt_q == 4'h9);

  // Acknowledge decision per byte
  always_comb begin
    ack_ok_d = 1'b0;
    case (phase_q)
      qdw_pkg::PH_ADDR: ack_ok_d = (byte_val[7:3] == qdw_pkg::ADDR_FIXED) &&
                          (byte_val[2:1] == sync2_q[1:0]) && !byte_val[0];
      qdw_pkg::PH_CTRL: ack_ok_d = 1'b1;
      qdw_pkg::PH_HIGH: ack_ok_d = 1'b1;
      qdw_pkg::PH_LOW:  ack_ok_d = 1'b1;
      default: ack_ok_d = 1'b0;
    endcase
  end

  // Phase after the acknowledge slot
  always_comb begin
    case (phase_q)
      qdw_pkg::PH_ADDR: phase_d = ack_ok_q ? qdw_pkg::PH_CTRL :
                                             qdw_pkg::PH_IGN;
      qdw_pkg::PH_CTRL: phase_d = qdw_pkg::PH_HIGH;
      qdw_pkg::PH_HIGH: phase_d = qdw_pkg::PH_LOW;
      qdw_pkg::PH_LOW:  phase_d = powerdown_select_flag ?
                                  qdw_pkg::PH_IGN : qdw_pkg::PH_HIGH;
      qdw_pkg::PH_IGN:  phase_d = qdw_pkg::PH_IGN;
      default:          phase_d = qdw_pkg::PH_IDLE;
    endcase
  end

  // Bit counter, shift register and phase
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q    <= 4'h0;
      shift_q  <= 7'h00;
      phase_q  <= qdw_pkg::PH_IDLE;
      ack_ok_q <= 1'b0;
    end else if (start_seen) begin
      cnt_q   <= 4'h0;
      phase_q <= qdw_pkg::PH_ADDR;
    end else if (stop_seen) begin
      cnt_q   <= 4'h0;
      phase_q <= qdw_pkg::PH_IDLE;
    end else if (phase_q != qdw_pkg::PH_IDLE) begin
      if (scl_rise && cnt_q < 4'h7) begin
        shift_q <= byte_val[6:0];
        cnt_q   <= cnt_q + 4'h1;
      end else if (byte_done) begin
        cnt_q    <= 4'h8;
        ack_ok_q <= ack_ok_d;
      end else if (scl_fall && cnt_q == 4'h8) begin
        cnt_q <= 4'h9;
      end else if (ack_end) begin
        cnt_q   <= 4'h0;
        phase_q <= phase_d;
      end
    end
  end

  // Acknowledge drive: low from fall after bit 8 to end of ninth clock
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sda_oe_q <= 1'b0;
    end else if (start_seen || stop_seen || ack_end) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall && cnt_q == 4'h8) begin
      sda_oe_q <= ack_ok_q;
    end
  end

  assign link.sda_o_s  = 1'b0;
  assign link.sda_oe_s = sda_oe_q;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      control_byte_store_q <= 8'h00;
      high_byte_staging_q  <= 8'h00;
    end else if (byte_done) begin
      if (phase_q == qdw_pkg::PH_CTRL) begin
        control_byte_store_q <= byte_val;
      end
      if (phase_q == qdw_pkg::PH_HIGH) begin
        high_byte_staging_q <= byte_val;
      end
    end
  end

  // action and channel from control byte
  assign load_mode = control_byte_store_q[qdw_pkg::CTRL_LOAD_LSB +: 2];
  assign sel       = control_byte_store_q[qdw_pkg::CTRL_SEL_LSB +: 2];
  assign powerdown_select_flag =
    control_byte_store_q[qdw_pkg::CTRL_PD_BIT];

  // lower six bits ignored in power-down
  assign new_val = powerdown_select_flag ?
    {high_byte_staging_q[qdw_pkg::PD_CODE_HI],
     high_byte_staging_q[qdw_pkg::PD_CODE_LO], 8'h00} :
    {2'b00, high_byte_staging_q};

  // update at end of low-byte acknowledge
  assign do_update = ack_end & (phase_q == qdw_pkg::PH_LOW) & ack_ok_q;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < qdw_pkg::CHANNELS; i++) begin
        temp_q[i] <= qdw_pkg::CHAN_RESET;
        conv_q[i] <= qdw_pkg::CHAN_RESET;
      end
    end else if (do_update) begin
      for (int i = 0; i < qdw_pkg::CHANNELS; i++) begin
        case (load_mode)
          qdw_pkg::LOAD_TEMP: begin
            if (sel == 2'(i)) begin
              temp_q[i] <= new_val;
            end
          end
          qdw_pkg::LOAD_ONE: begin
            if (sel == 2'(i)) begin
              temp_q[i] <= new_val;
              conv_q[i] <= new_val;
            end
          end
          qdw_pkg::LOAD_ALL: begin
            if (sel == 2'(i)) begin
              temp_q[i] <= new_val;
              conv_q[i] <= new_val;
            end else begin
              conv_q[i] <= temp_q[i];
            end
          end
          default: begin
            if (control_byte_store_q[qdw_pkg::CTRL_SEL_HI]) begin
              temp_q[i] <= new_val;
              conv_q[i] <= new_val;
            end else begin
              conv_q[i] <= temp_q[i];
            end
          end
        endcase
      end
    end
  end

  // Update strobe for the analog side
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      update_q <= 1'b0;
    end else begin
      update_q <= do_update;
    end
  end

  // Converter contents straight from flops
  assign conv_channel_a_out = conv_q[0];
  assign conv_channel_b_out = conv_q[1];
  assign conv_channel_c_out = conv_q[2];
  assign conv_channel_d_out = conv_q[3];
  assign update_out         = update_q;
endmodule

// ==== rtl/qdw_pkg.sv ====
// Shared constants and types for the quad converter write port
package qdw_pkg;
  // Fixed upper five bits of the slave address
  localparam logic [4:0] ADDR_FIXED  = 5'h13;
  localparam int         BYTE_BITS   = 8;
  localparam int         CHANNELS    = 4;
  localparam int         CHAN_W      = 10;
  // Control byte field positions
  localparam int         CTRL_PD_BIT   = 0;
  localparam int         CTRL_SEL_LSB  = 1;
  localparam int         CTRL_SEL_HI   = 2;
  localparam int         CTRL_LOAD_LSB = 4;
  // Power-down code bits within the high byte
  localparam int         PD_CODE_HI  = 7;
  localparam int         PD_CODE_LO  = 6;
  // Load modes
  localparam logic [1:0] LOAD_TEMP   = 2'h0;
  localparam logic [1:0] LOAD_ONE    = 2'h1;
  localparam logic [1:0] LOAD_ALL    = 2'h2;
  localparam logic [1:0] LOAD_BCAST  = 2'h3;
  // Reset value of temporary and converter registers
  localparam logic [9:0] CHAN_RESET  = 10'h000;
  // Controller register offsets and fields
  localparam logic [11:0] REG_CONTROL = 12'h000;
  localparam logic [11:0] REG_DATA    = 12'h004;
  localparam logic [11:0] REG_STATUS  = 12'h008;
  localparam int          CFG_PINS_LSB = 8;
  localparam int          DATA_LOW_LSB = 8;
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_NACK    = 1;
  // Bus clock timing
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          SCL_PERIOD_NS = 10000;
  localparam int          SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // Device byte phase, Gray along address-control-high-low
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_ADDR = 3'h1,
    PH_CTRL = 3'h3,
    PH_HIGH = 3'h2,
    PH_LOW  = 3'h6,
    PH_IGN  = 3'h4
  } qdw_phase_t;
  // Controller sequencer states
  typedef enum logic [1:0] {
    M_IDLE  = 2'h0,
    M_START = 2'h1,
    M_BITS  = 2'h3,
    M_STOP  = 2'h2
  } qdw_mstate_t;
endpackage

// ==== rtl/qdw_link_if.sv ====
// Two-wire link between controller and converter write port
`timescale 1ns/1ns
interface qdw_link_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_s;
  logic sda_oe_s;
  logic scl;
  logic sda;
  // Open-drain wires with pull-up
  assign scl = scl_oe_m ? scl_o_m : 1'b1;
  assign sda = (sda_oe_m ? sda_o_m : 1'b1) & (sda_oe_s ? sda_o_s : 1'b1);
  modport dev (input scl, input sda, output sda_o_s, output sda_oe_s);
  modport ctl (input scl, input sda, output scl_o_m, output scl_oe_m,
               output sda_o_m, output sda_oe_m);
endinterface

// ==== rtl/qdw_ctl.sv ====
// Controller end: APB-driven two-wire write sequencer
`timescale 1ns/1ns
module qdw_ctl #(
  parameter int QUARTER_CYC = qdw_pkg::SCL_QUARTER_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Link
  qdw_link_if.ctl          link
);
  if (QUARTER_CYC < 4 || QUARTER_CYC > 65536) begin : g_bad_quarter
    $error("QUARTER_CYC outside two-flop sampling or counter range");
  end

  logic [9:0]              cfg_q;
  logic [15:0]             data_q;
  logic [31:0]             prdata_q;
  logic                    nack_q;
  logic                    sda_s1_q;
  logic                    sda_s2_q;
  logic [15:0]             tick_cnt_q;
  logic                    tick;
  logic [1:0]              q_q;
  logic [3:0]              bit_q;
  logic [1:0]              byte_q;
  logic [7:0]              cur_byte;
  logic                    scl_oe_q;
  logic                    sda_oe_q;
  logic                    launch;
  logic                    mapped;
  qdw_pkg::qdw_mstate_t    st_q;

  // Register decode; zero wait states, error on unmapped
  assign mapped      = (paddr_in == qdw_pkg::REG_CONTROL) ||
                       (paddr_in == qdw_pkg::REG_DATA) ||
                       (paddr_in == qdw_pkg::REG_STATUS);
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~mapped;
  assign prdata_out  = prdata_q;
  // Write to the data word starts a transfer only while idle
  assign launch = psel_in & penable_in & pwrite_in & st_q == qdw_pkg::M_IDLE &
                  (paddr_in == qdw_pkg::REG_DATA);

  // Configuration and data words
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_q  <= 10'h000;
      data_q <= 16'h0000;
    end else if (psel_in && penable_in && pwrite_in) begin
      if (paddr_in == qdw_pkg::REG_CONTROL) begin
        cfg_q <= pwdata_in[9:0];
      end
      if (launch) begin
        data_q <= pwdata_in[15:0];
      end
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_in && !penable_in) begin
      case (paddr_in)
        qdw_pkg::REG_CONTROL: prdata_q <= {22'h000000, cfg_q};
        qdw_pkg::REG_DATA:    prdata_q <= {16'h0000, data_q};
        qdw_pkg::REG_STATUS:  prdata_q <= {30'h00000000, nack_q,
                                           st_q != qdw_pkg::M_IDLE};
        default:              prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Bus data line passes two flops before use
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // Quarter-period tick, held still while idle
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt_q <= 16'h0000;
    end else if (st_q == qdw_pkg::M_IDLE || tick) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end
  assign tick = (tick_cnt_q == 16'(QUARTER_CYC - 1));

  // address with write bit, then control byte
  // low byte always follows the high byte
  always_comb begin
    case (byte_q)
      2'h0:    cur_byte = {qdw_pkg::ADDR_FIXED, cfg_q[9:8], 1'b0};
      2'h1:    cur_byte = cfg_q[7:0];
      2'h2:    cur_byte = data_q[7:0];
      default: cur_byte = data_q[15:8];
    endcase
  end

  // Sequencer: start, four bytes with acknowledge, stop
  // one pair per transfer, each with fresh addressing
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q     <= qdw_pkg::M_IDLE;
      q_q      <= 2'h0;
      bit_q    <= 4'h0;
      byte_q   <= 2'h0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      nack_q   <= 1'b0;
    end else if (launch) begin
      st_q   <= qdw_pkg::M_START;
      q_q    <= 2'h0;
      nack_q <= 1'b0;
    end else if (tick) begin
      q_q <= q_q + 2'h1;
      case (st_q)
        qdw_pkg::M_START: begin
          if (q_q == 2'h1) sda_oe_q <= 1'b1;
          if (q_q == 2'h3) begin
            scl_oe_q <= 1'b1;
            st_q     <= qdw_pkg::M_BITS;
            bit_q    <= 4'h0;
            byte_q   <= 2'h0;
          end
        end
        qdw_pkg::M_BITS: begin
          case (q_q)
            2'h0: sda_oe_q <= (bit_q == 4'h8) ? 1'b0 :
                              ~cur_byte[3'(4'h7 - bit_q)];
            2'h1: scl_oe_q <= 1'b0;
            2'h2: if (bit_q == 4'h8 && sda_s2_q) nack_q <= 1'b1;
            default: begin
              scl_oe_q <= 1'b1;
              if (bit_q != 4'h8) begin
                bit_q <= bit_q + 4'h1;
              end else if (nack_q || byte_q == 2'h3) begin
                st_q <= qdw_pkg::M_STOP;
              end else begin
                bit_q  <= 4'h0;
                byte_q <= byte_q + 2'h1;
              end
            end
          endcase
        end
        qdw_pkg::M_STOP: begin
          if (q_q == 2'h0) sda_oe_q <= 1'b1;
          if (q_q == 2'h1) scl_oe_q <= 1'b0;
          if (q_q == 2'h2) sda_oe_q <= 1'b0;
          if (q_q == 2'h3) st_q <= qdw_pkg::M_IDLE;
        end
        default: st_q <= qdw_pkg::M_IDLE;
      endcase
    end
  end

  // Open-drain drive: enable pulls low
  assign link.scl_o_m  = 1'b0;
  assign link.scl_oe_m = scl_oe_q;
  assign link.sda_o_m  = 1'b0;
  assign link.sda_oe_m = sda_oe_q;
endmodule

// ==== bench/qdw_link_props.sv ====
// Link protocol assertions for the two-wire write port
`timescale 1ns/1ns
module qdw_link_props #(
  parameter int QUARTER_CYC = qdw_pkg::SCL_QUARTER_CYC
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  // Link signals
  input  wire logic scl_o_m,
  input  wire logic scl_oe_m,
  input  wire logic sda_o_m,
  input  wire logic sda_oe_m,
  input  wire logic sda_o_s,
  input  wire logic sda_oe_s,
  input  wire logic scl,
  input  wire logic sda
);
  // One scl period plus sync slack
  localparam int ACK_MAX = 4 * QUARTER_CYC + 4;
  logic        scl_q;
  logic        sda_q;
  logic [3:0]  bit_cnt_q;
  int unsigned since_fall_q;
  int unsigned ack_len_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  // Wire history, bit count and ack length
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_q        <= 1'b1;
      sda_q        <= 1'b1;
      bit_cnt_q    <= 4'h0;
      since_fall_q <= 0;
      ack_len_q    <= 0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && sda_q && !sda) begin
        bit_cnt_q <= 4'h0;
      end else if (!scl_q && scl) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (scl_q && !scl && bit_cnt_q == 4'h9) begin
        bit_cnt_q <= 4'h0;
      end
      // Saturate so long idle spells cannot wrap
      if (scl_q && !scl) since_fall_q <= 0;
      else if (since_fall_q < 255) since_fall_q <= since_fall_q + 1;
      ack_len_q <= sda_oe_s ? ack_len_q + 1 : 0;
    end
  end

  a_ack_ninth_bit: assert property (
    $rose(sda_oe_s) |-> bit_cnt_q == 4'h8)
    else $error("ack not after the eighth bit");
  a_ack_near_fall: assert property (
    $rose(sda_oe_s) |-> since_fall_q <= 6)
    else $error("ack began far from an scl fall");
  a_ack_release: assert property (
    $fell(sda_oe_s) |-> !scl && since_fall_q <= 6)
    else $error("ack released away from scl fall");
  a_sda_scl_low: assert property (
    $changed(sda_oe_s) |-> !scl)
    else $error("device moved sda while scl high");
  a_ack_holds: assert property (
    $rose(scl) && sda_oe_s |-> sda_oe_s [*8])
    else $error("ack dropped during ninth clock");
  a_ack_bounded: assert property (
    ack_len_q <= ACK_MAX)
    else $error("device held sda too long");
  a_ack_pulls_low: assert property (
    sda_oe_s |-> !sda)
    else $error("sda high while device pulls");
  a_open_drain: assert property (
    !sda_o_s && !sda_o_m && !scl_o_m)
    else $error("open-drain output drove high");
  a_start_quiet: assert property (
    scl && sda_q && !sda |-> !sda_oe_s)
    else $error("device pulled sda at start");
endmodule

// ==== bench/quad_dac_i2c_write_port_bench.sv ====
// Bench: APB controller writing the converter port over the link
`timescale 1ns/1ns
module quad_dac_i2c_write_port_bench;
  localparam int QC = 8;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        upd;
  logic [1:0]  straps;
  logic [9:0]  conv [4];
  logic [9:0]  tmp_m [4];
  logic [9:0]  cnv_m [4];
  int          bad_count;
  int          n_checks;
  int          upd_seen;
  int          upd_exp;
  int          seed;

  qdw_link_if link ();
  qdw_ctl #(.QUARTER_CYC(QC)) u_qdw_ctl (
    .ref_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .link(link));
  qdw_dev u_qdw_dev (
    .ref_clk_in(clk), .rst_b_in(rst_b), .link(link),
    .addr_pin_hi_in(straps[1]), .addr_pin_lo_in(straps[0]),
    .conv_channel_a_out(conv[0]), .conv_channel_b_out(conv[1]),
    .conv_channel_c_out(conv[2]), .conv_channel_d_out(conv[3]),
    .update_out(upd));
  qdw_link_props #(.QUARTER_CYC(QC)) u_qdw_link_props (
    .ref_clk_in(clk), .rst_b_in(rst_b), .scl_o_m(link.scl_o_m),
    .scl_oe_m(link.scl_oe_m), .sda_o_m(link.sda_o_m),
    .sda_oe_m(link.sda_oe_m), .sda_o_s(link.sda_o_s),
    .sda_oe_s(link.sda_oe_s), .scl(link.scl), .sda(link.sda));

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Count update pulses seen at the converter end
  always @(posedge clk) begin
    if (upd === 1'b1) upd_seen++;
  end

  task automatic fail(input string msg);
    bad_count++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_chan(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("channel %h want %h", got, exp));
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("word %h want %h", got, exp));
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail("apb answer never came");
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [9:0] val_of(input logic [7:0] c,
                                        input logic [7:0] hi);
    return c[0] ? {hi[7:6], 8'h00} : {2'h0, hi};
  endfunction

  // Expected register effect of one accepted pair
  task automatic model(input logic [7:0] c, input logic [7:0] hi);
    logic [9:0] v;
    logic [1:0] s;
    v = val_of(c, hi);
    s = c[2:1];
    if (c[5:4] != 2'h3) tmp_m[s] = v;
    if (c[5:4] == 2'h1) cnv_m[s] = v;
    for (int i = 0; i < 4; i++) begin
      if (c[5:4] == 2'h3 && s[1]) tmp_m[i] = v;
      if (c[5]) cnv_m[i] = tmp_m[i];
    end
    // Every acked low byte strobes, whatever the load mode
    upd_exp++;
  endtask

  // Full write: target, control, high and low byte, then checks
  task automatic xfer(input logic [1:0] pins, input logic [7:0] c,
                      input logic [7:0] hi, input logic [7:0] lo);
    logic [31:0] rd;
    logic        e;
    int          n;
    apb(1'b1, 12'h000, {22'h0, pins, c}, rd, e);
    apb(1'b1, 12'h004, {16'h0, lo, hi}, rd, e);
    n = 0;
    do begin
      apb(1'b0, 12'h008, 32'h0, rd, e);
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      fail("transfer never finished");
      final_report();
    end
    if (pins == straps) model(c, hi);
    chk_word(rd & 32'h3, {30'h0, pins != straps, 1'b0});
    repeat (8) @(posedge clk);
    for (int i = 0; i < 4; i++) chk_chan(conv[i], cnv_m[i]);
    chk_word(32'(upd_seen), 32'(upd_exp));
  endtask

  initial begin
    logic [31:0] rd;
    logic        e;
    logic [31:0] r;
    seed      = 87300;
    rst_b     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    straps    = 2'h2;
    bad_count = 0;
    n_checks  = 0;
    upd_seen  = 0;
    upd_exp   = 0;
    for (int i = 0; i < 4; i++) begin
      tmp_m[i] = 10'h000;
      cnv_m[i] = 10'h000;
    end
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) chk_chan(conv[i], 10'h000);
    // Unmapped address errors and reads zero
    apb(1'b0, 12'h00c, 32'h0, rd, e);
    chk_word({31'h0, e}, 32'h1);
    chk_word(rd, 32'h0);
    // Corner cases: every load mode, both broadcast kinds, a stray address
    xfer(2'h2, 8'h17, 8'hc0, 8'h5a);
    xfer(2'h2, 8'h02, 8'h3c, 8'h00);
    xfer(2'h2, 8'h30, 8'h00, 8'hff);
    xfer(2'h1, 8'h10, 8'hff, 8'h00);
    xfer(2'h2, 8'h22, 8'ha5, 8'h33);
    xfer(2'h2, 8'h35, 8'h80, 8'hff);
    xfer(2'h2, 8'h14, 8'h00, 8'h00);
    // Random control bytes; power-down high bytes keep six zeros
    repeat (20) begin
      r = $random(seed);
      // power-down high byte keeps six zeros
      if (r[0]) r[13:8] = 6'h00;
      xfer(straps, {2'h0, r[5:0]}, r[15:8], r[23:16]);
    end
    final_report();
  end
endmodule
